// >>> hdl/csac_regs.v
// Two-wire slave holding the shared answer-to-reset counts and slot 3-5 status.
// Assumes scl/sda, presence pins and supervisor level are asynchronous pins;
// event pulses and page inputs come from logic on ref_clk_in.
`timescale 1ns/1ps
`default_nettype none
`include "csac_defs.vh"
module csac_regs #(
    parameter [6:0] DEV_ADDR = `CSAC_DEV_ADDR // Bus address, value arbitrary
) (
    input wire ref_clk_in,                // 250 MHz clock
    input wire nrst_in,                   // Power-on reset, active low
    input wire scl_in,                    // Bus clock pin
    input wire sda_in,                    // Bus data pin level
    output wire sda_out,                  // Bus data drive value, always low
    output reg sda_oe_out,                // High while pulling data low
    input wire [1:0] slot1_page_in,       // Page of slot 1 control
    input wire [1:0] slot2_page_in,       // Page of slot 2 control
    input wire supervisor_fault_in,       // Voltage supervisor active
    input wire [2:0] card_presence_pin_in, // Presence pins, slots 5..3
    input wire [2:0] card_active_in,      // Cards activated
    input wire [2:0] early_evt_in,        // Too-early answer pulses
    input wire [2:0] mute_evt_in,         // No-answer pulses
    input wire [2:0] overload_evt_in,     // Overload pulses
    input wire [2:0] low_power_clock_in,  // Power-down clock switched
    output wire [2:0] low_voltage_select_out,  // 1.8 V select
    output wire [2:0] card_io_enable_out,      // I/O enable
    output wire [5:0] page_select_out,         // Page fields, 2 bits per slot
    output wire [2:0] power_down_select_out,   // Power-down
    output wire [2:0] high_voltage_select_out, // 5 V versus 3 V
    output wire [2:0] warm_reset_out,          // Warm reset request
    output wire [2:0] start_out,               // Start, activation level
    output reg [7:0] atr_short_count_out,      // Short count
    output reg [15:0] atr_long_count_out,      // Long count
    output reg interrupt_out_n                 // Interrupt, active low
);
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_ADDR = 5'h02;
    localparam [4:0] ST_SUB = 5'h04;
    localparam [4:0] ST_WR = 5'h08;
    localparam [4:0] ST_RD = 5'h10;

    reg rst_s1_reg, rst_n_reg;
    reg [`CSAC_NSYNC-1:0] sync1_reg, sync2_reg;
    reg scl_d_reg, sda_d_reg;
    reg [4:0] state_reg;
    reg [3:0] bit_cnt_reg;
    reg [7:0] shift_reg, tx_reg, sub_reg, rd_snap_reg;
    reg rw_reg;
    reg skip_fall_reg;
    reg [2:0] rd_slot_reg, rd_clr_reg, wr_stb_reg;
    reg [7:0] wr_data_reg;
    reg [7:0] rdata;
    wire [7:0] status [0:2];
    wire [7:0] ctrl [0:2];
    wire [2:0] flag_any;

    assign sda_out = 1'b0;

    // Returns the counter byte picked by a page, zero on the control page
    function [7:0] page_byte;
        input [1:0] page;
        input [7:0] s_cnt;
        input [15:0] l_cnt;
        begin
            case (page)
                `CSAC_PAGE_SHORT: page_byte = s_cnt;
                `CSAC_PAGE_HIGH: page_byte = l_cnt[15:8];
                `CSAC_PAGE_LOW: page_byte = l_cnt[7:0];
                default: page_byte = 8'h00;
            endcase
        end
    endfunction

    // One-hot slot 3..5 hit for a sub-address
    function [2:0] slot_hit;
        input [7:0] a;
        begin
            slot_hit = {a == `CSAC_ADDR_SLOT5,
                        a == `CSAC_ADDR_SLOT4,
                        a == `CSAC_ADDR_SLOT3};
        end
    endfunction

    // Page of the counter address in use, either slot address works
    function [1:0] cnt_page;
        input [7:0] a;
        input [1:0] p1;
        input [1:0] p2;
        begin
            if (a == `CSAC_ADDR_SLOT1)
                cnt_page = p1;
            else if (a == `CSAC_ADDR_SLOT2)
                cnt_page = p2;
            else
                cnt_page = 2'h0;
        end
    endfunction

    always @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg <= rst_s1_reg;
        end
    end

    // Pins pass two flops; the edge detectors compare the second stage with one more flop
    wire [`CSAC_NSYNC-1:0] pins_in = {supervisor_fault_in, sda_in, scl_in,
                                      card_presence_pin_in};
    always @(posedge ref_clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            sync1_reg <= {`CSAC_NSYNC{1'b1}};
            sync2_reg <= {`CSAC_NSYNC{1'b1}};
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            sync1_reg <= pins_in;
            sync2_reg <= sync1_reg;
            scl_d_reg <= sync2_reg[3];
            sda_d_reg <= sync2_reg[4];
        end
    end

    wire scl_s = sync2_reg[3];
    wire sda_s = sync2_reg[4];
    wire sup_s = sync2_reg[5];
    wire scl_rise = scl_s & ~scl_d_reg;
    wire scl_fall = ~scl_s & scl_d_reg;
    wire bus_start = scl_s & scl_d_reg & ~sda_s & sda_d_reg;
    wire bus_stop = scl_s & scl_d_reg & sda_s & ~sda_d_reg;

    wire [2:0] sub_slots = slot_hit(sub_reg);
    wire [1:0] wr_page = cnt_page(sub_reg, slot1_page_in, slot2_page_in);

    always @* begin
        case (sub_slots)
            3'h1: rdata = status[0];
            3'h2: rdata = status[1];
            3'h4: rdata = status[2];
            default: rdata = page_byte(wr_page, atr_short_count_out, atr_long_count_out);
        endcase
    end

    // Bus slave: one register address byte, then data bytes to the same address
    always @(posedge ref_clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            sub_reg <= 8'h00;
            rw_reg <= 1'b0;
            skip_fall_reg <= 1'b0;
            sda_oe_out <= 1'b0;
            rd_slot_reg <= 3'h0;
            rd_snap_reg <= 8'h00;
            rd_clr_reg <= 3'h0;
            wr_stb_reg <= 3'h0;
            wr_data_reg <= 8'h00;
        end else begin
            rd_clr_reg <= 3'h0;
            wr_stb_reg <= 3'h0;
            if (bus_start) begin
                state_reg <= ST_ADDR;
                bit_cnt_reg <= 4'h0;
                sda_oe_out <= 1'b0;
                skip_fall_reg <= 1'b1;
            end else if (bus_stop) begin
                state_reg <= ST_IDLE;
                sda_oe_out <= 1'b0;
            end else if (scl_fall && skip_fall_reg) begin
                // The start's own clock fall carries no bit; counting it loses the last bit
                skip_fall_reg <= 1'b0;
            end else if (scl_rise && state_reg != ST_IDLE) begin
                if (bit_cnt_reg != `CSAC_ACK_BIT)
                    shift_reg <= {shift_reg[6:0], sda_s};
                else if (state_reg == ST_RD) begin
                    rd_clr_reg <= rd_slot_reg;
                    if (sda_s)
                        state_reg <= ST_IDLE;
                end
            end else if (scl_fall && state_reg != ST_IDLE) begin
                if (bit_cnt_reg == `CSAC_ACK_BIT) begin
                    bit_cnt_reg <= 4'h0;
                    sda_oe_out <= 1'b0;
                    case (state_reg)
                        ST_ADDR: state_reg <= rw_reg ? ST_RD : ST_SUB;
                        ST_SUB: state_reg <= ST_WR;
                        default: state_reg <= state_reg;
                    endcase
                    if ((state_reg == ST_ADDR && rw_reg) || state_reg == ST_RD) begin
                        tx_reg <= rdata;
                        rd_snap_reg <= rdata;
                        rd_slot_reg <= sub_slots;
                        sda_oe_out <= ~rdata[7];
                    end
                end else begin
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (state_reg == ST_RD) begin
                        tx_reg <= {tx_reg[6:0], 1'b0};
                        sda_oe_out <= (bit_cnt_reg == `CSAC_LAST_BIT) ? 1'b0 : ~tx_reg[6];
                    end else if (bit_cnt_reg == `CSAC_LAST_BIT) begin
                        case (state_reg)
                            ST_ADDR: begin
                                if (shift_reg[7:1] == DEV_ADDR) begin
                                    rw_reg <= shift_reg[0];
                                    sda_oe_out <= 1'b1;
                                end else begin
                                    state_reg <= ST_IDLE;
                                end
                            end
                            ST_SUB: begin
                                sub_reg <= shift_reg;
                                sda_oe_out <= 1'b1;
                            end
                            ST_WR: begin
                                wr_data_reg <= shift_reg;
                                wr_stb_reg <= slot_hit(sub_reg);
                                sda_oe_out <= 1'b1;
                            end
                            default: sda_oe_out <= 1'b0;
                        endcase
                    end
                end
            end
        end
    end

    // Counter writes use the byte just taken; the page names the target
    reg cnt_wr_reg;
    always @(posedge ref_clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg)
            cnt_wr_reg <= 1'b0;
        else
            cnt_wr_reg <= scl_fall && state_reg == ST_WR && bit_cnt_reg == `CSAC_LAST_BIT
                          && !bus_start && !bus_stop;
    end

    always @(posedge ref_clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            atr_short_count_out <= `CSAC_RST_SHORT;
            atr_long_count_out <= {`CSAC_RST_HIGH, `CSAC_RST_LOW};
        end else if (cnt_wr_reg) begin
            case (wr_page)
                `CSAC_PAGE_SHORT: atr_short_count_out <= wr_data_reg;
                `CSAC_PAGE_HIGH: atr_long_count_out[15:8] <= wr_data_reg;
                `CSAC_PAGE_LOW: atr_long_count_out[7:0] <= wr_data_reg;
                default: atr_short_count_out <= atr_short_count_out;
            endcase
        end
    end

    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_slot
            csac_slot u_slot (
                .clk_in(ref_clk_in),
                .rst_n_in(rst_n_reg),
                .wr_stb_in(wr_stb_reg[i]),
                .wr_data_in(wr_data_reg),
                .rd_clr_in(rd_clr_reg[i]),
                .rd_snap_in(rd_snap_reg),
                .active_in(card_active_in[i]),
                .early_evt_in(early_evt_in[i]),
                .mute_evt_in(mute_evt_in[i]),
                .overload_evt_in(overload_evt_in[i]),
                .supply_fault_in(sup_s),
                .low_power_clock_in(low_power_clock_in[i]),
                .presence_level_in(sync2_reg[i]),
                .status_out(status[i]),
                .ctrl_out(ctrl[i]),
                .flag_any_out(flag_any[i])
            );
            assign low_voltage_select_out[i] = ctrl[i][`CSAC_BIT_LOWV];
            assign card_io_enable_out[i] = ctrl[i][`CSAC_BIT_IOEN];
            assign page_select_out[2*i+1:2*i] = ctrl[i][`CSAC_PAGE_HI:`CSAC_PAGE_LO];
            assign power_down_select_out[i] = ctrl[i][`CSAC_BIT_PWRDN];
            assign high_voltage_select_out[i] = ctrl[i][`CSAC_BIT_HIGHV];
            assign warm_reset_out[i] = ctrl[i][`CSAC_BIT_WARM];
            assign start_out[i] = ctrl[i][`CSAC_BIT_START];
        end
    endgenerate

    // Supervisor level keeps the line low even after the flags are read
    always @(posedge ref_clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg)
            interrupt_out_n <= 1'b0;
        else
            interrupt_out_n <= ~(|flag_any | sup_s);
    end
endmodule
`default_nettype wire

// >>> hdl/csac_slot.v
// One status/control register of card slots three to five.
// Assumes events are one-cycle pulses on ref clock; levels already synchronised.
`timescale 1ns/1ps
`default_nettype none
`include "csac_defs.vh"
module csac_slot (
    input wire clk_in,             // Ref clock
    input wire rst_n_in,           // Synchronised reset, active low
    input wire wr_stb_in,          // Host write to this slot
    input wire [7:0] wr_data_in,   // Host write byte
    input wire rd_clr_in,          // Status byte read completed
    input wire [7:0] rd_snap_in,   // Status byte as it was sent
    input wire active_in,          // Card activated
    input wire early_evt_in,       // Too-early answer pulse
    input wire mute_evt_in,        // No-answer pulse
    input wire overload_evt_in,    // Overload or overheat pulse
    input wire supply_fault_in,    // Supervisor fault level
    input wire low_power_clock_in, // Power-down clock switched
    input wire presence_level_in,  // Presence pin level
    output wire [7:0] status_out,  // Read byte
    output reg [7:0] ctrl_out,     // Written control fields
    output wire flag_any_out       // Any interrupt flag set
);
    reg early_reg, mute_reg, overload_reg, supply_reg;
    reg [7:0] ctrl_next;
    wire card_present = ~presence_level_in;
    wire start_ok = ~supply_reg & ~overload_reg & card_present;

    assign status_out = {active_in, early_reg, mute_reg, overload_reg,
                         supply_reg, low_power_clock_in, 1'b0,
                         presence_level_in};
    assign flag_any_out = early_reg | mute_reg | overload_reg | supply_reg;

    // Set beats the read clear, and only bits sent as one are cleared
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            early_reg <= 1'b0;
            mute_reg <= 1'b0;
            overload_reg <= 1'b0;
            supply_reg <= 1'b1;
        end else begin
            early_reg <= (early_reg & ~(rd_clr_in & rd_snap_in[`CSAC_BIT_EARLY]))
                         | early_evt_in;
            mute_reg <= (mute_reg & ~(rd_clr_in & rd_snap_in[`CSAC_BIT_MUTE]))
                        | mute_evt_in;
            overload_reg <= (overload_reg & ~(rd_clr_in & rd_snap_in[`CSAC_BIT_OVERLOAD]))
                            | overload_evt_in;
            supply_reg <= (supply_reg & ~(rd_clr_in & rd_snap_in[`CSAC_BIT_SUPPLY]))
                          | supply_fault_in;
        end
    end

    always @* begin
        ctrl_next = ctrl_out;
        if (wr_stb_in) begin
            ctrl_next = wr_data_in;
            if (ctrl_out[`CSAC_BIT_START]) begin
                ctrl_next[`CSAC_BIT_LOWV] = ctrl_out[`CSAC_BIT_LOWV];
                ctrl_next[`CSAC_BIT_HIGHV] = ctrl_out[`CSAC_BIT_HIGHV];
            end
            if (wr_data_in[`CSAC_BIT_START] & ~start_ok)
                ctrl_next[`CSAC_BIT_START] = ctrl_out[`CSAC_BIT_START];
            if (ctrl_next[`CSAC_BIT_START] & ~ctrl_out[`CSAC_BIT_START])
                ctrl_next[`CSAC_BIT_WARM] = 1'b0;
        end
        if (mute_evt_in)
            ctrl_next[`CSAC_BIT_WARM] = 1'b0;
    end

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            ctrl_out <= 8'h00;
        else
            ctrl_out <= ctrl_next;
    end
endmodule
`default_nettype wire

// >>> pkg/csac_defs.vh
// Constants for the card slot status and answer-to-reset counter registers.
// Assumes inclusion by bare name from hdl/ files; definitions only.
`ifndef CSAC_DEFS_VH
`define CSAC_DEFS_VH
`define CSAC_DEV_ADDR 7'h24
`define CSAC_ADDR_SLOT1 8'h01
`define CSAC_ADDR_SLOT2 8'h02
`define CSAC_ADDR_SLOT3 8'h03
`define CSAC_ADDR_SLOT4 8'h04
`define CSAC_ADDR_SLOT5 8'h05
`define CSAC_PAGE_SHORT 2'h1
`define CSAC_PAGE_HIGH 2'h2
`define CSAC_PAGE_LOW 2'h3
`define CSAC_RST_SHORT 8'haa
`define CSAC_RST_HIGH 8'ha4
`define CSAC_RST_LOW 8'h74
`define CSAC_BIT_ACTIVE 7
`define CSAC_BIT_EARLY 6
`define CSAC_BIT_MUTE 5
`define CSAC_BIT_OVERLOAD 4
`define CSAC_BIT_SUPPLY 3
`define CSAC_BIT_LPCLK 2
`define CSAC_BIT_PRESENCE 0
`define CSAC_BIT_LOWV 7
`define CSAC_BIT_IOEN 6
`define CSAC_PAGE_HI 5
`define CSAC_PAGE_LO 4
`define CSAC_BIT_PWRDN 3
`define CSAC_BIT_HIGHV 2
`define CSAC_BIT_WARM 1
`define CSAC_BIT_START 0
`define CSAC_LAST_BIT 4'h7
`define CSAC_ACK_BIT 4'h8
`define CSAC_NSYNC 6
`endif

// >>> tb/csac_host.sv
// Two-wire bus host model for the slot register block.
// Assumes the bench resolves the data wire with a pull-up; pins move on falling ref edges.
`timescale 1ns/1ps
`default_nettype none
module csac_host (
    input wire logic clk_in, // Ref clock
    input wire logic sda_in, // Resolved data wire
    output logic scl_out, // Bus clock, still while idle
    output logic sda_low_out // High while pulling data low
);
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // A quarter of the 48 ns bus clock period
    task automatic qtr(input int n);
        repeat (3 * n) @(negedge clk_in);
    endtask
    task automatic start();
        qtr(1);
        sda_low_out = 1'b0;
        qtr(1);
        scl_out = 1'b1;
        qtr(1);
        sda_low_out = 1'b1;
        qtr(1);
        scl_out = 1'b0;
    endtask
    task automatic stop();
        qtr(1);
        sda_low_out = 1'b1;
        qtr(1);
        scl_out = 1'b1;
        qtr(1);
        sda_low_out = 1'b0;
        qtr(2);
    endtask
    // Nine clocks, MSB first; a one releases the wire so the slave can answer
    task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            qtr(1);
            sda_low_out = ~tx[i];
            qtr(1);
            scl_out = 1'b1;
            qtr(1);
            rx[i] = sda_in;
            qtr(1);
            scl_out = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// >>> tb/csac_regs_props.sv
// Concurrent checks on the ports of the card slot register block.
// Assumes one ref clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module csac_regs_props (
    input wire logic ref_clk_in, // Ref clock
    input wire logic nrst_in, // Reset, active low
    input wire logic scl_in, // Bus clock pin
    input wire logic sda_oe_out, // Data pull-down enable
    input wire logic supervisor_fault_in, // Supervisor level
    input wire logic [2:0] card_presence_pin_in, // Presence pins
    input wire logic [2:0] early_evt_in, // Early pulses
    input wire logic [2:0] mute_evt_in, // Mute pulses
    input wire logic [2:0] overload_evt_in, // Overload pulses
    input wire logic [2:0] low_voltage_select_out, // Low voltage select
    input wire logic [2:0] high_voltage_select_out, // High voltage select
    input wire logic [2:0] warm_reset_out, // Warm reset
    input wire logic [2:0] start_out, // Start
    input wire logic [7:0] atr_short_count_out, // Short count
    input wire logic [15:0] atr_long_count_out, // Long count
    input wire logic interrupt_out_n // Interrupt, active low
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!nrst_in);
    // One edge later, since the first edge in reset may still show unknowns
    rst_values_a: assert property (disable iff (1'b0) !nrst_in |=>
        atr_short_count_out == 8'haa && atr_long_count_out == 16'ha474 && !interrupt_out_n
        && !sda_oe_out) else $error("reset values wrong");
    evt_irq_a: assert property (|{early_evt_in, mute_evt_in, overload_evt_in}
        |-> ##2 !interrupt_out_n) else $error("interrupt not low after event");
    supv_irq_a: assert property (supervisor_fault_in [*6] |-> !interrupt_out_n)
        else $error("interrupt high while supervisor active");
    oe_rise_a: assert property ($rose(sda_oe_out) |-> !scl_in)
        else $error("data driven while bus clock high");
    start_gate_a: assert property ((start_out & ~$past(start_out) & card_presence_pin_in)
        == 3'h0) else $error("start accepted without card");
    volt_hold_a: assert property ((((low_voltage_select_out ^ $past(low_voltage_select_out))
        | (high_voltage_select_out ^ $past(high_voltage_select_out))) & $past(start_out))
        == 3'h0) else $error("voltage changed while started");
    warm_clear_a: assert property (|mute_evt_in |-> ##2
        (warm_reset_out & $past(mute_evt_in, 2)) == 3'h0) else $error("warm not cleared");
    irq_release_a: assert property ($rose(interrupt_out_n) |-> scl_in
        && !supervisor_fault_in) else $error("interrupt released outside a read");
    cover property ($rose(start_out[0]));
    cover property ($rose(interrupt_out_n));
    cover property ($rose(sda_oe_out));
endmodule
`default_nettype wire

// >>> tb/csac_regs_test.sv
// Self-checking bench for the card slot status and count registers.
// Assumes csac_regs, csac_host and csac_regs_props; data wire has a pull-up here.
`timescale 1ns/1ps
`default_nettype none
`include "csac_defs.vh"
module csac_regs_test;
    logic ref_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic scl, sda_low, sda_out, sda_oe_out, interrupt_out_n;
    logic [1:0] pg1 = 2'h1;
    logic [1:0] pg2 = 2'h1;
    logic supv = 1'b0;
    logic [2:0] pin = 3'b111;
    logic [2:0] act = 3'b101;
    logic [2:0] lpc = 3'b010;
    logic [2:0] early = 3'h0;
    logic [2:0] mute = 3'h0;
    logic [2:0] ovl = 3'h0;
    logic [2:0] low_voltage_select_out, card_io_enable_out, power_down_select_out;
    logic [2:0] high_voltage_select_out, warm_reset_out, start_out;
    logic [5:0] page_select_out;
    logic [7:0] atr_short_count_out, rx;
    logic [15:0] atr_long_count_out;
    logic [8:0] r9;
    logic [7:0] rv [1:3] = '{8'haa, 8'ha4, 8'h74};
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    wire sda = ~(sda_low | (sda_oe_out & ~sda_out));
    csac_regs uut (.ref_clk_in, .nrst_in, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe_out,
        .slot1_page_in(pg1), .slot2_page_in(pg2), .supervisor_fault_in(supv),
        .card_presence_pin_in(pin), .card_active_in(act), .early_evt_in(early),
        .mute_evt_in(mute), .overload_evt_in(ovl), .low_power_clock_in(lpc),
        .low_voltage_select_out, .card_io_enable_out, .page_select_out,
        .power_down_select_out, .high_voltage_select_out, .warm_reset_out, .start_out,
        .atr_short_count_out, .atr_long_count_out, .interrupt_out_n);
    csac_host h (.clk_in(ref_clk_in), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
    always #2 ref_clk_in = ~ref_clk_in;
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Whole run needs roughly 19k cycles
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 80000) begin
            err_count++;
            $display("ERROR %0t run did not finish", $time);
            tally_and_finish();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic nak;
        h.start();
        h.byte_io({`CSAC_DEV_ADDR, 2'b01}, r9);
        nak = r9[0];
        h.byte_io({a, 1'b1}, r9);
        nak |= r9[0];
        h.byte_io({d, 1'b1}, r9);
        h.stop();
        chk(nak | r9[0], 1'b0);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        logic nak;
        h.start();
        h.byte_io({`CSAC_DEV_ADDR, 2'b01}, r9);
        nak = r9[0];
        h.byte_io({a, 1'b1}, r9);
        nak |= r9[0];
        h.start();
        h.byte_io({`CSAC_DEV_ADDR, 2'b11}, r9);
        nak |= r9[0];
        h.byte_io(9'h1ff, r9);
        rx = r9[8:1];
        h.stop();
        chk(nak, 1'b0);
        chk(rx, exp);
    endtask
    task automatic rd_all();
        for (int i = 0; i < 3; i++) begin
            rc(8'(3 + i), {act[i], 4'h1, lpc[i], 1'b0, pin[i]});
            chk(interrupt_out_n, i == 2);
        end
    endtask
    function automatic logic [7:0] ctl(input int i);
        return {low_voltage_select_out[i], card_io_enable_out[i], page_select_out[2*i+1 -: 2],
            power_down_select_out[i], high_voltage_select_out[i], warm_reset_out[i], start_out[i]};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask
    initial begin
        tick(8);
        nrst_in = 1'b1;
        tick(4);
        chk(interrupt_out_n, 1'b0);
        rd_all();
        for (int p = 1; p < 4; p++) begin
            pg1 = 2'(p);
            pg2 = 2'(p);
            rc(8'h01, rv[p]);
            wr(8'h02, 8'(8'h50 + p));
            rc(8'h01, 8'(8'h50 + p));
        end
        chk(atr_short_count_out, 8'h51);
        chk(atr_long_count_out, 16'h5253);
        pg1 = 2'h0;
        wr(8'h01, 8'h99);
        rc(8'h01, 8'h00);
        rc(8'h07, 8'h00);
        chk(atr_short_count_out, 8'h51);
        h.start();
        h.byte_io({`CSAC_DEV_ADDR ^ 7'h01, 2'b01}, r9);
        h.stop();
        chk(r9[0], 1'b1);
        for (int k = 0; k < 9; k++) begin
            {ovl, mute, early} = 9'(1 << k);
            tick(1);
            {ovl, mute, early} = 9'h0;
            tick(2);
            chk(interrupt_out_n, 1'b0);
            rc(8'(3 + k % 3), {act[k%3], 3'b100 >> (k / 3), 1'b0, lpc[k%3], 1'b0,
                pin[k%3]});
            rc(8'(3 + k % 3), {act[k%3], 3'b000, 1'b0, lpc[k%3], 1'b0, pin[k%3]});
            chk(interrupt_out_n, 1'b1);
        end
        supv = 1'b1;
        tick(12);
        chk(interrupt_out_n, 1'b0);
        rc(8'h03, {act[0], 4'h1, lpc[0], 1'b0, pin[0]});
        chk(interrupt_out_n, 1'b0);
        supv = 1'b0;
        tick(8);
        rd_all();
        wr(8'h04, 8'h41);
        chk(ctl(1), 8'h40);
        wr(8'h03, 8'hbf);
        chk(ctl(0), 8'hbe);
        pin[0] = 1'b0;
        tick(4);
        wr(8'h03, 8'hbf);
        chk(ctl(0), 8'hbd);
        wr(8'h03, 8'h01);
        chk(ctl(0), 8'h85);
        wr(8'h03, 8'h02);
        chk(ctl(0), 8'h86);
        mute = 3'b001;
        tick(1);
        mute = 3'h0;
        tick(3);
        chk(ctl(0), 8'h84);
        ovl = 3'b001;
        tick(1);
        ovl = 3'h0;
        wr(8'h03, 8'h01);
        chk(ctl(0), 8'h00);
        rc(8'h03, {act[0], 3'b011, 1'b0, lpc[0], 1'b0, 1'b0});
        chk(ctl(1), 8'h40);
        tally_and_finish();
    end
endmodule
bind csac_regs csac_regs_props u_props (.ref_clk_in, .nrst_in, .scl_in, .sda_oe_out,
    .supervisor_fault_in, .card_presence_pin_in, .early_evt_in, .mute_evt_in,
    .overload_evt_in, .low_voltage_select_out, .high_voltage_select_out, .warm_reset_out,
    .start_out, .atr_short_count_out, .atr_long_count_out, .interrupt_out_n);
`default_nettype wire
